// [upc_line_model.sv]
`timescale 1ns/1ps
module upc_line_model (
    input  wire logic       clk_i,
    input  wire logic       infrared_i,
    input  wire logic       drive_i,
    input  wire logic       data_i,
    input  wire logic [3:0] modem_i,
    output logic            rx_o,
    output logic [3:0]      modem_n_o
);
    // Line rests at its idle level outside frames
    always_ff @(posedge clk_i) begin
        rx_o <= drive_i ? data_i : !infrared_i;
    end
    // Asserted modem lines are driven low
    always_ff @(posedge clk_i) begin
        modem_n_o <= ~modem_i;
    end
endmodule

// [upc_pin_control.sv]
// Operation
// [R1] Idle receive level depends on infrared mode
// [R2] Host asserts request-to-send before auto flow
// [R3] Clear-to-send is input or auto gate
// [R4] Modem pins active low, usable as GPIO
// [R5] Power-save input blocks host bus access
// [R6] Strap selects strobe or direction bus
// [R7] Reset polarity follows bus strap
// [R8] Reset held at least minimum pulse width
// [R9] Reset drives transmit idle, ignores receive
// [R10] Interrupt pin style follows bus strap
// [R11] Infrared bit sets transmit idle level
// [R12] Reset and power-save pass synchronisers
// [R13] Bus strap sampled as static configuration
//
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/1ps
module upc_pin_control
    import upc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    input  wire logic       wb_we_i,
    input  wire logic [7:0] wb_adr_i,
    input  wire logic [3:0] wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]     wb_dat_o,
    output logic            wb_ack_o,
    output logic            wb_err_o,
    input  wire logic       bus_select_i,
    input  wire logic       ext_reset_i,
    input  wire logic       power_save_in_i,
    input  wire logic       rx_i,
    input  wire logic       tx_data_i,
    input  wire logic       tx_active_i,
    input  wire logic       rx_ready_i,
    output logic            rx_data_o,
    output logic            rx_idle_o,
    output logic            tx_o,
    output logic            rts_n_o,
    output logic            dtr_n_o,
    input  wire logic       cts_n_i,
    input  wire logic       dsr_n_i,
    input  wire logic       carrier_detect_in_n_i,
    input  wire logic       ring_indicator_in_n_i,
    output logic            tx_allowed_o,
    output logic            irq_o,
    output logic            int_pin_o,
    output logic            int_pin_oe_n_o
);
    localparam int NSYNC = 8;

    typedef enum logic [1:0] {
        UPC_RST_RUN   = 2'b00,
        UPC_RST_HOLD  = 2'b01,
        UPC_RST_STRAP = 2'b10
    } upc_rst_type;

    upc_sync_if #(.WIDTH(NSYNC)) sync_bus ();

    logic [7:0]  modem_control_reg;
    logic [7:0]  enhanced_feature_reg;
    logic [7:0]  interrupt_enable_reg;
    logic [3:0]  irq_status;
    logic [3:0]  irq_mask;
    logic [3:0]  prev_modem;
    logic        strobe_bus;
    logic        rx_s;
    logic        cts_s;
    logic        dsr_s;
    logic        cd_s;
    logic        ri_s;
    logic        save_s;
    logic        ext_rst_s;
    logic        strap_s;
    logic        dev_reset;
    logic [7:0]  hold_cnt;
    upc_rst_type rst_state;
    logic        wb_req;
    logic        wb_hit;
    logic [31:0] next_rdata;
    logic [3:0]  modem_now;
    logic [3:0]  modem_events;
    logic        wr_ok;

    function automatic logic [7:0] merge_byte(input logic [7:0] old,
                                              input logic [31:0] dat,
                                              input logic [3:0] sel);
        merge_byte = sel[0] ? dat[7:0] : old;
    endfunction

    // Strap, reset, power-save, modem and receive pins pass two flops [R12]
    assign sync_bus.raw = {bus_select_i, ext_reset_i, power_save_in_i,
                           ring_indicator_in_n_i, carrier_detect_in_n_i,
                           dsr_n_i, cts_n_i, rx_i};
    assign {strap_s, ext_rst_s, save_s, ri_s, cd_s, dsr_s, cts_s, rx_s} = sync_bus.synced;

    upc_sync #(.WIDTH(NSYNC)) u_sync (
        .clk_i (clk_i),
        .port  (sync_bus.dst)
    );

    // Strap latched once, after bus reset release [R13]
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_state  <= UPC_RST_STRAP;
            strobe_bus <= 1'b1;
        end else begin
            case (rst_state)
                UPC_RST_STRAP: begin
                    strobe_bus <= strap_s; // [R6]
                    rst_state  <= UPC_RST_RUN;
                end
                UPC_RST_RUN: begin
                    if (dev_reset) begin
                        rst_state <= UPC_RST_HOLD;
                    end
                end
                UPC_RST_HOLD: begin
                    if (!dev_reset) begin
                        rst_state <= UPC_RST_RUN;
                    end
                end
                default: rst_state <= UPC_RST_RUN;
            endcase
        end
    end

    // Pin reset polarity follows strap [R7]
    logic pin_active;
    assign pin_active = strobe_bus ? ext_rst_s : !ext_rst_s;

    // Pulse shorter than minimum is not honoured [R8]
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_cnt <= 8'h00;
        end else if (!pin_active || rst_state == UPC_RST_STRAP) begin
            hold_cnt <= 8'h00;
        end else if (hold_cnt != 8'hFF) begin
            hold_cnt <= hold_cnt + 8'h01;
        end
    end

    assign dev_reset = rst_i || (pin_active && hold_cnt >= 8'(RESET_MIN_CYCLES - 1)
                                 && rst_state != UPC_RST_STRAP);

    // Bus access blocked in power-save [R5]
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign wb_hit = (wb_adr_i == REG_MODEM_CONTROL) || (wb_adr_i == REG_ENHANCED_FEATURE)
                 || (wb_adr_i == REG_INTERRUPT_ENABLE) || (wb_adr_i == REG_MODEM_STATUS)
                 || (wb_adr_i == REG_IRQ_STATUS) || (wb_adr_i == REG_IRQ_MASK)
                 || (wb_adr_i == REG_PIN_STATUS);
    assign wr_ok  = wb_req && wb_hit && wb_we_i && !save_s; // [R5]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req && wb_hit;
            wb_err_o <= wb_req && !wb_hit;
            if (wb_req && wb_hit && !wb_we_i) begin
                wb_dat_o <= save_s ? 32'h0000_0000 : next_rdata; // [R5]
            end
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (wb_adr_i)
            REG_MODEM_CONTROL:    next_rdata[7:0] = modem_control_reg;
            REG_ENHANCED_FEATURE: next_rdata[7:0] = enhanced_feature_reg;
            REG_INTERRUPT_ENABLE: next_rdata[7:0] = interrupt_enable_reg;
            REG_MODEM_STATUS: begin
                next_rdata[MSR_CTS] = !cts_s; // [R3]
                next_rdata[MSR_DSR] = !dsr_s; // [R4]
                next_rdata[MSR_RI]  = !ri_s;
                next_rdata[MSR_CD]  = !cd_s;
                next_rdata[3:0]     = irq_status;
            end
            REG_IRQ_STATUS:       next_rdata[3:0] = irq_status;
            REG_IRQ_MASK:         next_rdata[3:0] = irq_mask;
            REG_PIN_STATUS: begin
                next_rdata[PST_BUS_SEL] = strobe_bus;
                next_rdata[PST_RX_IDLE] = rx_idle_o;
                next_rdata[PST_SAVE]    = save_s;
            end
            default:              next_rdata = 32'h0000_0000;
        endcase
    end

    // Control registers, cleared by device reset [R9]
    always_ff @(posedge clk_i) begin
        if (dev_reset) begin
            modem_control_reg    <= MCR_RESET;
            enhanced_feature_reg <= EFR_RESET;
            interrupt_enable_reg <= IER_RESET;
            irq_mask             <= IRQ_RESET;
        end else if (wr_ok) begin
            case (wb_adr_i)
                REG_MODEM_CONTROL:
                    modem_control_reg <= merge_byte(modem_control_reg, wb_dat_i, wb_sel_i);
                REG_ENHANCED_FEATURE:
                    enhanced_feature_reg <= merge_byte(enhanced_feature_reg, wb_dat_i, wb_sel_i);
                REG_INTERRUPT_ENABLE:
                    interrupt_enable_reg <= merge_byte(interrupt_enable_reg, wb_dat_i, wb_sel_i);
                REG_IRQ_MASK: begin
                    if (wb_sel_i[0]) begin
                        irq_mask <= wb_dat_i[3:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // Modem input change events, set wins over clear [R3] [R4]
    assign modem_now    = {cd_s, ri_s, dsr_s, cts_s};
    assign modem_events = {prev_modem[3] ^ cd_s,
                           prev_modem[2] & !ri_s,
                           prev_modem[1] ^ dsr_s,
                           prev_modem[0] ^ cts_s};

    always_ff @(posedge clk_i) begin
        if (dev_reset) begin
            prev_modem <= 4'hF;
            irq_status <= IRQ_RESET;
        end else begin
            prev_modem <= modem_now;
            irq_status <= (irq_status & ~((wr_ok && wb_adr_i == REG_IRQ_STATUS
                                           && wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0))
                        | modem_events; // [R3]
        end
    end

    // Interrupt output; with auto CTS on, CTS change also gated by enable bit [R3]
    logic [3:0] irq_gate;
    assign irq_gate = irq_status & irq_mask
                    & {3'b111, interrupt_enable_reg[IER_CTS] | !enhanced_feature_reg[EFR_AUTO_CTS]};

    always_ff @(posedge clk_i) begin
        if (dev_reset) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |irq_gate;
        end
    end

    // Interrupt pin style follows strap [R10]
    always_comb begin
        if (strobe_bus) begin
            int_pin_o      = irq_o;
            int_pin_oe_n_o = !modem_control_reg[MCR_OUT_EN];
        end else begin
            int_pin_o      = 1'b0;
            int_pin_oe_n_o = !irq_o;
        end
    end

    // Modem outputs active low [R4]
    always_ff @(posedge clk_i) begin
        if (dev_reset) begin
            dtr_n_o <= 1'b1;
            rts_n_o <= 1'b1;
        end else begin
            dtr_n_o <= !modem_control_reg[MCR_DTR];
            // Auto RTS relies on host asserting RTS first [R2]
            if (enhanced_feature_reg[EFR_AUTO_RTS] && modem_control_reg[MCR_RTS]) begin
                rts_n_o <= !rx_ready_i;
            end else begin
                rts_n_o <= !modem_control_reg[MCR_RTS];
            end
        end
    end

    // CTS gate for auto flow control [R3]
    always_ff @(posedge clk_i) begin
        if (dev_reset) begin
            tx_allowed_o <= 1'b0;
        end else begin
            tx_allowed_o <= enhanced_feature_reg[EFR_AUTO_CTS] ? !cts_s : 1'b1;
        end
    end

    // Transmit idle level per infrared bit [R11], high in reset [R9]
    always_ff @(posedge clk_i) begin
        if (dev_reset) begin
            tx_o <= 1'b1; // [R9]
        end else if (tx_active_i) begin
            tx_o <= tx_data_i;
        end else begin
            tx_o <= !modem_control_reg[MCR_INFRARED]; // [R11]
        end
    end

    // Receive ignored in reset; idle level per mode [R1] [R9]
    always_ff @(posedge clk_i) begin
        if (dev_reset) begin
            rx_data_o <= 1'b1;
            rx_idle_o <= 1'b1;
        end else begin
            rx_data_o <= modem_control_reg[MCR_INFRARED] ? !rx_s : rx_s;
            rx_idle_o <= (rx_s == !modem_control_reg[MCR_INFRARED]); // [R1]
        end
    end

    a_tx_reset_high: assert property (@(posedge clk_i) // [R9]
        $past(dev_reset) && !rst_i |-> tx_o == 1'b1)
        else $error("tx not high after reset");

    a_rx_reset_held: assert property (@(posedge clk_i) // [R9]
        $past(dev_reset) |-> rx_data_o == 1'b1 && rx_idle_o == 1'b1)
        else $error("rx not held in reset");

    a_tx_idle_level: assert property (@(posedge clk_i) disable iff (dev_reset) // [R11]
        !$past(tx_active_i) && !$past(dev_reset) |-> tx_o == !$past(modem_control_reg[MCR_INFRARED]))
        else $error("tx idle level wrong");

    a_rx_idle_flag: assert property (@(posedge clk_i) disable iff (dev_reset) // [R1]
        !$past(dev_reset) |-> rx_idle_o == ($past(rx_s) != $past(modem_control_reg[MCR_INFRARED])))
        else $error("rx idle flag wrong");

    a_save_blocks_write: assert property (@(posedge clk_i) disable iff (dev_reset) // [R5]
        save_s && wb_req && wb_we_i && wb_adr_i == REG_MODEM_CONTROL
        |=> $stable(modem_control_reg))
        else $error("write taken in power save");

    a_int_pin_style: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
        !strobe_bus |-> int_pin_o == 1'b0 && int_pin_oe_n_o == !irq_o)
        else $error("open drain interrupt wrong");

    a_cts_gate: assert property (@(posedge clk_i) disable iff (dev_reset) // [R3]
        enhanced_feature_reg[EFR_AUTO_CTS] && $stable(enhanced_feature_reg) ##1 $stable(cts_s)
        |-> tx_allowed_o == !cts_s)
        else $error("cts gate wrong");

    a_dtr_follows: assert property (@(posedge clk_i) disable iff (dev_reset) // [R4]
        !$past(dev_reset) |-> dtr_n_o == !$past(modem_control_reg[MCR_DTR]))
        else $error("dtr level wrong");

    a_reset_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
        rst_state == UPC_RST_RUN && pin_active [*2] |-> dev_reset)
        else $error("pin reset not honoured");
endmodule

// [upc_pin_control_bench.sv]
`timescale 1ns/1ps
module upc_pin_control_bench;
    import upc_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] rdat;
    logic        rerr;
    logic [31:0] wb_rd;
    logic        ack;
    logic        err;
    logic        bus_sel = 1'b1;
    logic        ext_rst = 1'b0;
    logic        psave = 1'b0;
    logic        tx_data = 1'b0;
    logic        tx_act = 1'b0;
    logic        rx_rdy = 1'b1;
    logic        ir = 1'b0;
    logic        drv = 1'b0;
    logic        dbit = 1'b0;
    logic [3:0]  modem = 4'h0;
    logic        rx;
    logic [3:0]  modem_n;
    logic        rx_data, rx_idle, tx, rts_n, dtr_n, tx_ok, irq, ipin, ioe_n;
    logic [7:0]  m;
    logic        line;
    int          error_cnt = 0;
    int          total_checks = 0;

    upc_line_model upc_line_model_i (
        .clk_i(clk_i), .infrared_i(ir), .drive_i(drv), .data_i(dbit),
        .modem_i(modem), .rx_o(rx), .modem_n_o(modem_n)
    );
    upc_pin_control upc_pin_control_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_rd),
        .wb_ack_o(ack), .wb_err_o(err), .bus_select_i(bus_sel), .ext_reset_i(ext_rst),
        .power_save_in_i(psave), .rx_i(rx), .tx_data_i(tx_data), .tx_active_i(tx_act),
        .rx_ready_i(rx_rdy), .rx_data_o(rx_data), .rx_idle_o(rx_idle), .tx_o(tx),
        .rts_n_o(rts_n), .dtr_n_o(dtr_n), .cts_n_i(modem_n[0]), .dsr_n_i(modem_n[1]),
        .carrier_detect_in_n_i(modem_n[2]), .ring_indicator_in_n_i(modem_n[3]),
        .tx_allowed_o(tx_ok), .irq_o(irq), .int_pin_o(ipin), .int_pin_oe_n_o(ioe_n)
    );

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic final_report();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Classic single cycle, waits for ack or err
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h1;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1 && err !== 1'b1);
        rdat = wb_rd;
        rerr = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        sel <= 4'h0;
    endtask

    function automatic logic exp_tx(logic [7:0] mc, logic act, logic d);
        return act ? d : !mc[MCR_INFRARED];
    endfunction

    initial begin
        void'($urandom(32'hd6d4b3a5));
        idle(12);
        chk(32'(tx), 32'h0000_0001);
        chk(32'({rx_data, rts_n, dtr_n, irq}), 32'h0000_000E);
        rst_i <= 1'b0;
        idle(2);
        wb(0, REG_PIN_STATUS, 0);
        chk(rdat, 32'h0000_0003);
        for (int a = 0; a < 12; a += 4) begin
            wb(0, 8'(a), 0);
            chk(rdat, 32'h0000_0000);
        end
        wb(0, 8'h20, 0);
        chk(32'(rerr), 32'h0000_0001);
        for (int i = 0; i < 10; i++) begin
            m = 8'($urandom) & 8'h43;
            tx_act <= 1'($urandom);
            tx_data <= 1'($urandom);
            drv <= 1'($urandom);
            dbit <= 1'($urandom);
            ir <= m[MCR_INFRARED];
            wb(1, REG_MODEM_CONTROL, {24'h0, m});
            idle(6);
            line = drv ? dbit : !m[MCR_INFRARED];
            chk(32'(tx), 32'(exp_tx(m, tx_act, tx_data)));
            chk(32'({dtr_n, rts_n}), 32'({!m[0], !m[1]}));
            chk(32'(rx_data), 32'(line ^ m[MCR_INFRARED]));
            chk(32'(rx_idle), 32'(line == !m[MCR_INFRARED]));
        end
        drv <= 1'b0;
        tx_act <= 1'b0;
        wb(1, REG_MODEM_CONTROL, 32'h0000_0003);
        wb(1, REG_IRQ_STATUS, 32'h0000_000F);
        wb(1, REG_IRQ_MASK, 32'h0000_0001);
        modem <= 4'h1;
        idle(8);
        chk(32'(irq), 32'h0000_0001);
        wb(0, REG_MODEM_STATUS, 0);
        chk(rdat & 32'h0000_00F0, 32'h0000_0010);
        wb(1, REG_IRQ_MASK, 32'h0000_0000);
        idle(3);
        chk(32'(irq), 32'h0000_0000);
        wb(1, REG_IRQ_MASK, 32'h0000_0001);
        wb(1, REG_IRQ_STATUS, 32'h0000_0001);
        idle(3);
        chk(32'(irq), 32'h0000_0000);
        modem <= 4'hF;
        wb(1, REG_ENHANCED_FEATURE, 32'h0000_0080);
        idle(8);
        wb(0, REG_MODEM_STATUS, 0);
        chk(rdat & 32'h0000_00F0, 32'h0000_00F0);
        chk(rdat & 32'h0000_000A, 32'h0000_000A);
        chk(32'(tx_ok), 32'h0000_0001);
        modem <= 4'hE;
        idle(8);
        chk(32'(tx_ok), 32'h0000_0000);
        wb(1, REG_INTERRUPT_ENABLE, 32'h0000_00C0);
        wb(1, REG_ENHANCED_FEATURE, 32'h0000_0040);
        rx_rdy <= 1'b0;
        idle(4);
        chk(32'({tx_ok, rts_n}), 32'h0000_0003);
        rx_rdy <= 1'b1;
        idle(4);
        chk(32'(rts_n), 32'h0000_0000);
        wb(1, REG_MODEM_CONTROL, 32'h0000_000B);
        wb(1, REG_IRQ_STATUS, 32'h0000_000F);
        idle(3);
        chk(32'({ipin, ioe_n}), 32'h0000_0000);
        modem <= 4'hF;
        idle(8);
        chk(32'({ipin, ioe_n}), 32'h0000_0002);
        wb(1, REG_MODEM_CONTROL, 32'h0000_0003);
        idle(3);
        chk(32'(ioe_n), 32'h0000_0001);
        psave <= 1'b1;
        idle(4);
        wb(1, REG_MODEM_CONTROL, 32'h0000_0000);
        wb(0, REG_MODEM_CONTROL, 0);
        chk(rdat, 32'h0000_0000);
        psave <= 1'b0;
        idle(4);
        wb(0, REG_MODEM_CONTROL, 0);
        chk(rdat, 32'h0000_0003);
        ext_rst <= 1'b1;
        idle(4);
        ext_rst <= 1'b0;
        idle(4);
        wb(0, REG_MODEM_CONTROL, 0);
        chk(rdat | 32'({dtr_n, rts_n} ^ 2'b11), 32'h0000_0000);
        bus_sel <= 1'b0;
        ext_rst <= 1'b1;
        rst_i <= 1'b1;
        idle(12);
        rst_i <= 1'b0;
        idle(2);
        wb(0, REG_PIN_STATUS, 0);
        chk(rdat & 32'h0000_0001, 32'h0000_0000);
        chk(32'({ipin, ioe_n}), 32'h0000_0001);
        wb(1, REG_MODEM_CONTROL, 32'h0000_0001);
        ext_rst <= 1'b0;
        idle(4);
        ext_rst <= 1'b1;
        idle(4);
        wb(0, REG_MODEM_CONTROL, 0);
        chk(rdat | 32'(!dtr_n), 32'h0000_0000);
        final_report();
    end

    // Run needs under 1500 cycles
    initial begin
        idle(5000);
        error_cnt++;
        final_report();
    end
endmodule

// [upc_pkg.sv]
package upc_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_MODEM_CONTROL    = 8'h00;
    localparam logic [7:0] REG_ENHANCED_FEATURE = 8'h04;
    localparam logic [7:0] REG_INTERRUPT_ENABLE = 8'h08;
    localparam logic [7:0] REG_MODEM_STATUS     = 8'h0C;
    localparam logic [7:0] REG_IRQ_STATUS       = 8'h10;
    localparam logic [7:0] REG_IRQ_MASK         = 8'h14;
    localparam logic [7:0] REG_PIN_STATUS       = 8'h18;
    // Modem control fields
    localparam int MCR_DTR      = 0;
    localparam int MCR_RTS      = 1;
    localparam int MCR_OUT_EN   = 3;
    localparam int MCR_INFRARED = 6;
    // Enhanced feature fields
    localparam int EFR_AUTO_RTS = 6;
    localparam int EFR_AUTO_CTS = 7;
    // Interrupt enable fields
    localparam int IER_RTS      = 6;
    localparam int IER_CTS      = 7;
    // Modem status fields
    localparam int MSR_DCTS     = 0;
    localparam int MSR_DDSR     = 1;
    localparam int MSR_TERI     = 2;
    localparam int MSR_DCD      = 3;
    localparam int MSR_CTS      = 4;
    localparam int MSR_DSR      = 5;
    localparam int MSR_RI       = 6;
    localparam int MSR_CD       = 7;
    // Pin status fields
    localparam int PST_BUS_SEL  = 0;
    localparam int PST_RX_IDLE  = 1;
    localparam int PST_SAVE     = 2;
    // Reset values
    localparam logic [7:0] MCR_RESET = 8'h00;
    localparam logic [7:0] EFR_RESET = 8'h00;
    localparam logic [7:0] IER_RESET = 8'h00;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    // Timing
    localparam int CLK_HZ           = 40_000_000;
    localparam int RESET_MIN_NS     = 40;
    localparam int RESET_MIN_CYCLES = (RESET_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int SYNC_STAGES      = 2;
endpackage

// [upc_sync.sv]
`timescale 1ns/1ps
module upc_sync
    import upc_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic clk_i,
    upc_sync_if.dst   port
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    // First stage read only by second stage
    always_ff @(posedge clk_i) begin
        stage1 <= port.raw;
        stage2 <= stage1;
    end

    assign port.synced = stage2;
endmodule

// [upc_sync_if.sv]
`timescale 1ns/1ps
interface upc_sync_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] synced;
    modport src (output raw, input synced);
    modport dst (input raw, output synced);
endinterface
